// *** design/eeprom_host_pkg.sv ***
package eeprom_host_pkg;

    // Clock
    localparam int CLK_MHZ = 40;

    function automatic int ns_to_cyc_min(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    // Widths and layout
    localparam int ADDR_W   = 13;
    localparam int DATA_W   = 8;
    localparam int PAGE_LSB = 5;
    localparam int CNT_W    = 19;
    localparam int TMR_W    = 8;
    localparam logic [7:0] ID_PAGE = 8'hFF;
    localparam int SYNC_STAGES = 2;

    // Pin timing in printed units
    localparam int T_ACC_NS = 250;
    localparam int T_DF_NS  = 60;
    localparam int T_WP_NS  = 100;
    localparam int T_AH_NS  = 50;
    localparam int T_WPH_NS = 50;
    localparam int T_DS_NS  = 50;
    localparam int T_HV_NS  = 1000;
    localparam int T_PLW_US = 150;
    localparam int T_WC_MS  = 2;
    localparam int T_PWR_MS = 5;
    localparam int T_CLR_MS = 10;

    // Derived cycle counts
    localparam int ACC_CYC = ns_to_cyc_min(T_ACC_NS);
    localparam int DF_CYC  = ns_to_cyc_min(T_DF_NS);
    localparam int WP_CYC  = ns_to_cyc_min(T_WP_NS);
    localparam int AH_CYC  = ns_to_cyc_min(T_AH_NS);
    localparam int WPH_CYC = ns_to_cyc_min(T_WPH_NS);
    localparam int DS_CYC  = ns_to_cyc_min(T_DS_NS);
    localparam int HV_CYC  = ns_to_cyc_min(T_HV_NS);

    localparam logic [TMR_W-1:0] RD_LEN  = TMR_W'(ACC_CYC + SYNC_STAGES);
    localparam logic [TMR_W-1:0] GAP_LEN = TMR_W'(DF_CYC);
    localparam logic [TMR_W-1:0] SU_LEN  = TMR_W'(1);
    localparam logic [TMR_W-1:0] WP_LEN  =
        TMR_W'((WP_CYC > DS_CYC) ? WP_CYC : DS_CYC);
    localparam logic [TMR_W-1:0] AH_LEN  =
        TMR_W'((AH_CYC > WPH_CYC) ? AH_CYC : WPH_CYC);
    localparam logic [TMR_W-1:0] HV_LEN  = TMR_W'(HV_CYC);

    localparam logic [CNT_W-1:0] PLW_CYC = CNT_W'(T_PLW_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] WC_CYC  = CNT_W'(T_WC_MS * 1000 * CLK_MHZ);
    localparam logic [CNT_W-1:0] PWR_CYC = CNT_W'(T_PWR_MS * 1000 * CLK_MHZ);
    localparam logic [CNT_W-1:0] CLR_CYC = CNT_W'(T_CLR_MS * 1000 * CLK_MHZ);
    localparam logic [CNT_W-1:0] BYTE_CYC =
        CNT_W'(2 + 1 + WP_CYC + AH_CYC + 4);

    // User commands
    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_CLEAR} op_t;

endpackage

// *** design/phase_timer_if.sv ***
interface phase_timer_if;
    logic                              start;
    logic [eeprom_host_pkg::TMR_W-1:0] len;
    logic                              done;

    modport ctrl (output start, output len, input done);
    modport tmr  (input start, input len, output done);
endinterface

// *** design/phase_timer.sv ***
module phase_timer (
    // Clock and reset
    input  wire logic  ref_clk,
    input  wire logic  nrst,
    // Control
    phase_timer_if.tmr t
);
    typedef struct packed {
        logic [eeprom_host_pkg::TMR_W-1:0] cnt;
        logic                              done;
    } tmr_state_t;

    tmr_state_t s_q;
    tmr_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (t.start) begin
            s_d.cnt = t.len;
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
        s_d.done = (s_d.cnt == '0);
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s_q <= '{cnt: '0, done: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign t.done = s_q.done;
endmodule // phase_timer

// *** design/eeprom_host.sv ***
module eeprom_host #(
    parameter logic [eeprom_host_pkg::CNT_W-1:0] PLW_CYC =
        eeprom_host_pkg::PLW_CYC,
    parameter logic [eeprom_host_pkg::CNT_W-1:0] POLL_CYC =
        eeprom_host_pkg::CNT_W'(eeprom_host_pkg::WC_CYC
                                + eeprom_host_pkg::PLW_CYC),
    parameter logic [eeprom_host_pkg::CNT_W-1:0] PWR_CYC =
        eeprom_host_pkg::PWR_CYC,
    parameter logic [eeprom_host_pkg::CNT_W-1:0] CLR_CYC =
        eeprom_host_pkg::CLR_CYC
) (
    // Clock and reset
    input  wire logic                                 ref_clk,
    input  wire logic                                 nrst,
    // User command port
    input  wire logic                                 cmd_valid,
    output logic                                      cmd_ready,
    input  wire eeprom_host_pkg::op_t                 cmd_op,
    input  wire logic [eeprom_host_pkg::ADDR_W-1:0]   cmd_addr,
    input  wire logic [eeprom_host_pkg::DATA_W-1:0]   cmd_wdata,
    input  wire logic                                 cmd_id,
    input  wire logic                                 cmd_last,
    // User answers
    output logic                                      rsp_valid,
    output logic [eeprom_host_pkg::DATA_W-1:0]        rsp_data,
    output logic                                      wr_done,
    output logic                                      wr_timeout,
    // Memory pins
    output logic [eeprom_host_pkg::ADDR_W-1:0]        addr_lines,
    output logic                                      chip_select_n,
    output logic                                      output_drive_n,
    output logic                                      write_strobe_n,
    output logic                                      oe_high_volt,
    output logic                                      addr_bit_nine_hv,
    input  wire logic [eeprom_host_pkg::DATA_W-1:0]   data_lines_i,
    output logic [eeprom_host_pkg::DATA_W-1:0]        data_lines_o,
    output logic                                      data_lines_oe
);
    typedef enum logic [3:0] {
        ST_PWRUP, ST_IDLE, ST_RD, ST_RD_GAP, ST_WR_SETUP, ST_WR_PULSE,
        ST_WR_HOLD, ST_LOAD, ST_CLR_SETUP, ST_CLR_PULSE, ST_CLR_HOLD
    } state_t;

    typedef struct packed {
        state_t                            st;
        logic [eeprom_host_pkg::CNT_W-1:0] cnt;
        logic [eeprom_host_pkg::ADDR_W-1:0] addr;
        logic                              ce_n;
        logic                              oe_n;
        logic                              we_n;
        logic                              oe_hv;
        logic                              a9_hv;
        logic [eeprom_host_pkg::DATA_W-1:0] dout;
        logic                              doe;
        logic                              ready;
        logic                              rsp_valid;
        logic [eeprom_host_pkg::DATA_W-1:0] rsp_data;
        logic                              wr_done;
        logic                              wr_timeout;
        logic [eeprom_host_pkg::DATA_W-1:0] sync1;
        logic [eeprom_host_pkg::DATA_W-1:0] sync2;
        logic                              poll;
        logic                              pend;
        eeprom_host_pkg::op_t              c_op;
        logic [eeprom_host_pkg::ADDR_W-1:0] c_addr;
        logic [eeprom_host_pkg::DATA_W-1:0] c_data;
        logic                              c_id;
        logic                              c_last;
        logic [eeprom_host_pkg::ADDR_W-1:0] last_addr;
        logic                              last_id;
        logic                              last_b7;
    } host_state_t;

    host_state_t s_q;
    host_state_t s_d;

    phase_timer_if tmr ();

    phase_timer u_timer (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .t       (tmr.tmr)
    );

    // Identification area sits on the top page
    function automatic logic [eeprom_host_pkg::ADDR_W-1:0] map_addr(
        input logic [eeprom_host_pkg::ADDR_W-1:0] a,
        input logic                               id
    );
        map_addr = id ? {eeprom_host_pkg::ID_PAGE,
                         a[eeprom_host_pkg::PAGE_LSB-1:0]} : a;
    endfunction

    function automatic state_t launch(input eeprom_host_pkg::op_t op);
        unique case (op)
            eeprom_host_pkg::OP_READ:  launch = ST_RD;
            eeprom_host_pkg::OP_WRITE: launch = ST_WR_SETUP;
            default:                   launch = ST_CLR_SETUP;
        endcase
    endfunction

    function automatic logic [eeprom_host_pkg::TMR_W-1:0] phase_len(
        input state_t st
    );
        unique case (st)
            ST_RD:                      phase_len = eeprom_host_pkg::RD_LEN;
            ST_RD_GAP:                  phase_len = eeprom_host_pkg::GAP_LEN;
            ST_WR_PULSE:                phase_len = eeprom_host_pkg::WP_LEN;
            ST_WR_HOLD:                 phase_len = eeprom_host_pkg::AH_LEN;
            ST_CLR_SETUP, ST_CLR_HOLD:  phase_len = eeprom_host_pkg::HV_LEN;
            default:                    phase_len = eeprom_host_pkg::SU_LEN;
        endcase
    endfunction

    logic room;
    logic same_page;

    always_comb begin
        s_d = s_q;
        s_d.rsp_valid  = 1'b0;
        s_d.wr_done    = 1'b0;
        s_d.wr_timeout = 1'b0;
        s_d.sync1 = data_lines_i;
        s_d.sync2 = s_q.sync1;
        s_d.cnt   = s_q.cnt + 1'b1;
        room = (s_q.cnt + eeprom_host_pkg::BYTE_CYC) < PLW_CYC;
        same_page = (cmd_op == eeprom_host_pkg::OP_WRITE)
            && (cmd_id == s_q.last_id)
            && (cmd_addr[eeprom_host_pkg::ADDR_W-1:eeprom_host_pkg::PAGE_LSB]
             == s_q.last_addr[eeprom_host_pkg::ADDR_W-1:
                              eeprom_host_pkg::PAGE_LSB]);
        if (cmd_valid && s_q.ready) begin
            s_d.c_op   = cmd_op;
            s_d.c_addr = cmd_addr;
            s_d.c_data = cmd_wdata;
            s_d.c_id   = cmd_id;
            s_d.c_last = cmd_last;
        end
        unique case (s_q.st)
            ST_PWRUP: begin
                if (s_q.cnt >= PWR_CYC) begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (cmd_valid && s_q.ready) begin
                    s_d.st  = launch(cmd_op);
                    s_d.cnt = '0;
                end
            end
            ST_RD: begin
                if (tmr.done) begin
                    s_d.st = ST_RD_GAP;
                    if (!s_q.poll) begin
                        s_d.rsp_valid = 1'b1;
                        s_d.rsp_data  = s_q.sync2;
                    end else if (s_q.sync2[7] == s_q.last_b7) begin
                        s_d.poll    = 1'b0;
                        s_d.wr_done = 1'b1;
                    end else if (s_q.cnt >= POLL_CYC) begin
                        s_d.poll       = 1'b0;
                        s_d.wr_timeout = 1'b1;
                    end
                end
            end
            ST_RD_GAP: begin
                if (tmr.done) begin
                    if (s_q.poll) begin
                        s_d.st = ST_RD;
                    end else if (s_q.pend) begin
                        s_d.pend = 1'b0;
                        s_d.st   = launch(s_q.c_op);
                        s_d.cnt  = '0;
                    end else begin
                        s_d.st = ST_IDLE;
                    end
                end
            end
            ST_WR_SETUP: begin
                s_d.last_addr = s_q.c_addr;
                s_d.last_id   = s_q.c_id;
                s_d.last_b7   = s_q.c_data[7];
                if (tmr.done) begin
                    s_d.st = ST_WR_PULSE;
                end
            end
            ST_WR_PULSE: begin
                if (tmr.done) begin
                    s_d.st = ST_WR_HOLD;
                end
            end
            ST_WR_HOLD: begin
                if (tmr.done) begin
                    s_d.st = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (s_q.c_last || !room) begin
                    s_d.st   = ST_RD;
                    s_d.poll = 1'b1;
                    s_d.cnt  = '0;
                end else if (cmd_valid && s_q.ready) begin
                    if (same_page) begin
                        s_d.st = ST_WR_SETUP;
                    end else begin
                        s_d.pend = 1'b1;
                        s_d.poll = 1'b1;
                        s_d.st   = ST_RD;
                        s_d.cnt  = '0;
                    end
                end
            end
            ST_CLR_SETUP: begin
                if (tmr.done) begin
                    s_d.st  = ST_CLR_PULSE;
                    s_d.cnt = '0;
                end
            end
            ST_CLR_PULSE: begin
                if (s_q.cnt >= CLR_CYC) begin
                    s_d.st = ST_CLR_HOLD;
                end
            end
            ST_CLR_HOLD: begin
                if (tmr.done) begin
                    s_d.st      = ST_IDLE;
                    s_d.wr_done = 1'b1;
                end
            end
        endcase
        // Pin levels follow the next phase
        s_d.ce_n = (s_d.st == ST_PWRUP) || (s_d.st == ST_IDLE)
                || (s_d.st == ST_RD_GAP) || (s_d.st == ST_LOAD);
        s_d.oe_n  = (s_d.st != ST_RD);
        s_d.we_n  = (s_d.st != ST_WR_PULSE) && (s_d.st != ST_CLR_PULSE);
        s_d.oe_hv = (s_d.st == ST_CLR_SETUP) || (s_d.st == ST_CLR_PULSE)
                 || (s_d.st == ST_CLR_HOLD);
        s_d.doe = (s_d.st == ST_WR_SETUP) || (s_d.st == ST_WR_PULSE)
               || (s_d.st == ST_WR_HOLD);
        s_d.dout  = s_d.c_data;
        s_d.addr  = s_d.poll ? map_addr(s_d.last_addr, s_d.last_id)
                             : map_addr(s_d.c_addr, s_d.c_id);
        s_d.a9_hv = !s_d.ce_n && !s_d.oe_hv
                 && (s_d.poll ? s_d.last_id : s_d.c_id);
        s_d.ready = (s_d.st == ST_IDLE)
                 || ((s_d.st == ST_LOAD) && !s_d.c_last
                     && ((s_d.cnt + eeprom_host_pkg::BYTE_CYC) < PLW_CYC));
        tmr.start = (s_d.st != s_q.st);
        tmr.len   = phase_len(s_d.st);
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s_q       <= '0;
            s_q.st    <= ST_PWRUP;
            s_q.ce_n  <= 1'b1;
            s_q.oe_n  <= 1'b1;
            s_q.we_n  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign cmd_ready        = s_q.ready;
    assign rsp_valid        = s_q.rsp_valid;
    assign rsp_data         = s_q.rsp_data;
    assign wr_done          = s_q.wr_done;
    assign wr_timeout       = s_q.wr_timeout;
    assign addr_lines       = s_q.addr;
    assign chip_select_n    = s_q.ce_n;
    assign output_drive_n   = s_q.oe_n;
    assign write_strobe_n   = s_q.we_n;
    assign oe_high_volt     = s_q.oe_hv;
    assign addr_bit_nine_hv = s_q.a9_hv;
    assign data_lines_o     = s_q.dout;
    assign data_lines_oe    = s_q.doe;
endmodule // eeprom_host

// *** verif/eeprom_host_monitor.sv ***
module eeprom_host_monitor #(
    parameter logic [eeprom_host_pkg::CNT_W-1:0] PLW_CYC =
        eeprom_host_pkg::PLW_CYC,
    parameter logic [eeprom_host_pkg::CNT_W-1:0] CLR_CYC =
        eeprom_host_pkg::CLR_CYC
) (
    // Clock and reset
    input wire logic                               ref_clk,
    input wire logic                               nrst,
    // Memory pins
    input wire logic [eeprom_host_pkg::ADDR_W-1:0] addr_lines,
    input wire logic                               chip_select_n,
    input wire logic                               output_drive_n,
    input wire logic                               write_strobe_n,
    input wire logic                               oe_high_volt,
    input wire logic [eeprom_host_pkg::DATA_W-1:0] data_lines_o,
    input wire logic                               data_lines_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    logic [eeprom_host_pkg::CNT_W-1:0] win_q;
    logic [eeprom_host_pkg::CNT_W-1:0] clr_q;
    logic [7:0]                        page_q;
    logic                              open_q;
    logic                              we_q;

    // Page load window and clear pulse length
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            {win_q, clr_q, page_q, open_q} <= '0;
            we_q <= 1'b1;
        end else begin
            we_q <= write_strobe_n;
            clr_q <= (!write_strobe_n && oe_high_volt) ? clr_q + 1'b1 : '0;
            if (!output_drive_n) begin
                open_q <= 1'b0;
            end else if (we_q && !write_strobe_n && !oe_high_volt
                         && !open_q) begin
                open_q <= 1'b1;
                win_q <= '0;
                page_q <= addr_lines[12:5];
            end else if (open_q) begin
                win_q <= win_q + 1'b1;
            end
        end
    end

    sequence strobe_low4;
        !write_strobe_n [*4];
    endsequence
    sequence strobes_idle8;
        write_strobe_n [*8];
    endsequence
    sequence hv_kept8;
        oe_high_volt [*8];
    endsequence

    host_no_contend_a: assert property (
        data_lines_oe |-> output_drive_n)
        else $error("host drives data while device output is on");
    read_pins_a: assert property (
        !output_drive_n && !oe_high_volt |-> !chip_select_n && write_strobe_n)
        else $error("read without select or with strobe low");
    write_gate_a: assert property (
        !write_strobe_n |-> !chip_select_n && (output_drive_n || oe_high_volt))
        else $error("write strobe without select or with output on");
    strobe_width_a: assert property (
        $fell(write_strobe_n) |-> strobe_low4)
        else $error("write strobe too short");
    addr_held_a: assert property (
        !write_strobe_n && !oe_high_volt |-> data_lines_oe && $stable(addr_lines))
        else $error("address or data drive moved during strobe");
    data_hold_a: assert property (
        $rose(write_strobe_n) && !oe_high_volt
            |-> data_lines_oe && $stable(data_lines_o))
        else $error("data not held at strobe rise");
    page_time_a: assert property (
        $fell(write_strobe_n) && !oe_high_volt && open_q |-> win_q < PLW_CYC)
        else $error("page byte after load window");
    page_same_a: assert property (
        $fell(write_strobe_n) && !oe_high_volt && open_q
            |-> addr_lines[12:5] == page_q)
        else $error("page bits changed within a load");
    clear_width_a: assert property (
        $rose(write_strobe_n) && $past(oe_high_volt) |-> clr_q >= CLR_CYC)
        else $error("clear pulse too short");
    hv_setup_a: assert property (
        $rose(oe_high_volt) |-> strobes_idle8)
        else $error("strobe too soon after high voltage");
    hv_hold_a: assert property (
        $rose(write_strobe_n) && $past(oe_high_volt) |-> hv_kept8)
        else $error("high voltage dropped too soon");
    clear_float_a: assert property (
        oe_high_volt |-> !data_lines_oe)
        else $error("data driven during clear");
endmodule // eeprom_host_monitor

bind eeprom_host eeprom_host_monitor #(
    .PLW_CYC(PLW_CYC),
    .CLR_CYC(CLR_CYC)
) monitor (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .addr_lines(addr_lines),
    .chip_select_n(chip_select_n),
    .output_drive_n(output_drive_n),
    .write_strobe_n(write_strobe_n),
    .oe_high_volt(oe_high_volt),
    .data_lines_o(data_lines_o),
    .data_lines_oe(data_lines_oe)
);

// *** verif/eeprom_dev_model.sv ***
module eeprom_dev_model #(
    parameter int LOAD_CYC = 40,
    parameter int PROG_CYC = 60,
    parameter int PWR_CYC  = 18,
    parameter int CLR_MIN  = 40
) (
    // Timing reference and supply
    input  wire logic        clk,
    input  wire logic        power_ok,
    // Device pins
    input  wire logic [12:0] addr,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        oe_hv,
    input  wire logic        a9_hv,
    // Shared data wire
    input  wire logic [7:0]  host_d,
    input  wire logic        host_oe,
    output logic [7:0]       bus_lvl
);
    logic [7:0]  mem [0:8191];
    logic [7:0]  idm [0:31];
    logic [7:0]  pbuf [0:31];
    logic [31:0] used;
    logic [12:0] a_q, last_a;
    logic [7:0]  last_d, lvl_q, q, page_q;
    logic        loading, busy, id_q, idw_q, low_q, idsel, wlow;
    int          load_t, prog_t, pwr_t, low_t;

    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        foreach (idm[i]) idm[i] = 8'h00;
        {loading, busy, low_q, used, lvl_q} = '0;
        {load_t, prog_t, pwr_t, low_t} = '0;
    end

    assign idsel = a9_hv && addr[12:5] == 8'hFF;
    assign wlow = !ce_n && !we_n && oe_n && !oe_hv;

    always @(posedge clk) begin
        low_q <= wlow;
        low_t <= (!ce_n && !we_n) ? low_t + 1 : 0;
        lvl_q <= bus_lvl;
        pwr_t <= !power_ok ? 0 : (pwr_t < PWR_CYC) ? pwr_t + 1 : pwr_t;
        if (wlow && !low_q) begin
            a_q <= addr;
            idw_q <= idsel;
        end
        if (low_q && !wlow && low_t >= 2 && pwr_t >= PWR_CYC && !busy) begin
            // Byte captured at each rising strobe; page and id at the first
            if (!loading) page_q <= a_q[12:5];
            if (!loading) id_q <= idw_q;
            used <= (loading ? used : 32'h0) | (32'h1 << a_q[4:0]);
            pbuf[a_q[4:0]] <= host_d;
            last_d <= host_d;
            last_a <= a_q;
            loading <= 1'b1;
            load_t <= 0;
        end else if (loading) begin
            load_t <= load_t + 1;
            if (load_t >= LOAD_CYC) begin
                loading <= 1'b0;
                busy <= 1'b1;
                prog_t <= 0;
            end
        end
        if (busy) begin
            prog_t <= prog_t + 1;
            if (prog_t >= PROG_CYC) begin
                for (int i = 0; i < 32; i++) begin
                    if (used[i] && id_q) idm[i] <= pbuf[i];
                    if (used[i] && !id_q) mem[{page_q, i[4:0]}] <= pbuf[i];
                end
                busy <= 1'b0;
            end
        end
        if (low_t >= CLR_MIN && we_n && !ce_n && oe_hv && !busy) begin
            foreach (mem[i]) mem[i] <= 8'hFF;
        end
    end

    always_comb begin
        q = idsel ? idm[addr[4:0]] : mem[addr];
        if ((loading || busy) && addr == last_a && idsel == id_q) begin
            q = {~last_d[7], last_d[6:0]};
        end
        if (!ce_n && !oe_n && we_n && !oe_hv) bus_lvl = q;
        else bus_lvl = host_oe ? host_d : ~lvl_q;
    end
endmodule // eeprom_dev_model

// *** verif/eeprom_host_tb.sv ***
module eeprom_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 ref_clk, nrst, cmd_valid, cmd_ready, cmd_id;
    logic                 cmd_last, rsp_valid, wr_done, wr_timeout;
    logic                 ce_n, oe_n, we_n, oe_hv, a9_hv, d_oe;
    logic [7:0]           rsp_data, d_in, d_out, cmd_wdata;
    logic [12:0]          cmd_addr, addr;
    eeprom_host_pkg::op_t cmd_op;
    int                   failures, n_compared;

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    eeprom_host #(.PLW_CYC(19'h258), .POLL_CYC(19'h320),
                  .PWR_CYC(19'h14), .CLR_CYC(19'h32)) dut (
        .ref_clk(ref_clk), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_id(cmd_id), .cmd_last(cmd_last),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .wr_done(wr_done),
        .wr_timeout(wr_timeout), .addr_lines(addr), .chip_select_n(ce_n),
        .output_drive_n(oe_n), .write_strobe_n(we_n),
        .oe_high_volt(oe_hv), .addr_bit_nine_hv(a9_hv),
        .data_lines_i(d_in), .data_lines_o(d_out), .data_lines_oe(d_oe));

    eeprom_dev_model dev (
        .clk(ref_clk), .power_ok(nrst), .addr(addr), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .oe_hv(oe_hv), .a9_hv(a9_hv),
        .host_d(d_out), .host_oe(d_oe), .bus_lvl(d_in));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Offer one command; with last set, wait for the write to finish
    task automatic go(input eeprom_host_pkg::op_t op, input logic [12:0] a,
                      input logic [7:0] d, input logic id, input logic last);
        int n;
        n = 0;
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_id = id;
        cmd_last = last;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 4000) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        @(negedge ref_clk);
        while (last && op != eeprom_host_pkg::OP_READ && wr_done !== 1'b1
               && wr_timeout !== 1'b1 && n < 4000) begin
            @(negedge ref_clk);
            n++;
        end
        if (last && op != eeprom_host_pkg::OP_READ) begin
            chk8({6'h00, wr_timeout, wr_done}, 8'h01);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d,
                      input logic id, input logic last);
        go(eeprom_host_pkg::OP_WRITE, a, d, id, last);
    endtask

    task automatic rd(input logic [12:0] a, input logic id, input logic [7:0] e);
        int n;
        n = 0;
        go(eeprom_host_pkg::OP_READ, a, 8'h00, id, 1'b0);
        while (rsp_valid !== 1'b1 && n < 4000) begin
            @(negedge ref_clk);
            n++;
        end
        chk8({7'h00, rsp_valid}, 8'h01);
        chk8(rsp_data, e);
    endtask

    task automatic t_power;
        for (int i = 0; i < 18; i++) begin
            chk8({7'h00, cmd_ready}, 8'h00);
            chk8({5'h00, ce_n, we_n, d_oe}, 8'h06);
            @(negedge ref_clk);
        end
        $display("test power done");
    endtask

    task automatic t_byte;
        wr(13'h0123, 8'hA5, 1'b0, 1'b1);
        wr(13'h0124, 8'h3C, 1'b0, 1'b1);
        rd(13'h0123, 1'b0, 8'hA5);
        rd(13'h0124, 1'b0, 8'h3C);
        $display("test byte done");
    endtask

    task automatic t_page;
        for (int i = 0; i < 32; i++) begin
            wr(13'h0040 + 13'(i), 8'(i * 7 + 1), 1'b0, i == 31);
        end
        for (int i = 0; i < 32; i++) begin
            rd(13'h0040 + 13'(i), 1'b0, 8'(i * 7 + 1));
        end
        $display("test page done");
    endtask

    // Reloads run the window out; later bytes start a new load
    task automatic t_window;
        for (int i = 0; i < 56; i++) begin
            wr(13'h00A0 + 13'(i % 32), 8'(i), 1'b0, i == 55);
        end
        rd(13'h00A0, 1'b0, 8'h20);
        rd(13'h00B6, 1'b0, 8'h36);
        rd(13'h00BF, 1'b0, 8'h1F);
        $display("test window done");
    endtask

    task automatic t_partial;
        wr(13'h0061, 8'h3C, 1'b0, 1'b1);
        wr(13'h007F, 8'h11, 1'b0, 1'b0);
        wr(13'h0060, 8'h22, 1'b0, 1'b0);
        wr(13'h0060, 8'hC4, 1'b0, 1'b1);
        rd(13'h0060, 1'b0, 8'hC4);
        rd(13'h007F, 1'b0, 8'h11);
        rd(13'h0061, 1'b0, 8'h3C);
        $display("test partial done");
    endtask

    task automatic t_ident;
        wr(13'h0005, 8'h9E, 1'b1, 1'b1);
        rd(13'h0005, 1'b1, 8'h9E);
        rd(13'h1FE5, 1'b0, 8'h00);
        $display("test ident done");
    endtask

    task automatic t_queue;
        wr(13'h0200, 8'h77, 1'b0, 1'b0);
        rd(13'h0123, 1'b0, 8'hA5);
        rd(13'h0200, 1'b0, 8'h77);
        $display("test queue done");
    endtask

    task automatic t_clear;
        go(eeprom_host_pkg::OP_CLEAR, 13'h0000, 8'h00, 1'b0, 1'b1);
        rd(13'h0123, 1'b0, 8'hFF);
        rd(13'h1FFF, 1'b0, 8'hFF);
        $display("test clear done");
    endtask

    task automatic complete_run;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #500000;
        failures++;
        complete_run();
    end

    initial begin
        {nrst, cmd_valid, cmd_id, cmd_last, cmd_addr, cmd_wdata} = '0;
        cmd_op = eeprom_host_pkg::OP_READ;
        failures = 0;
        n_compared = 0;
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        t_power();
        t_byte();
        t_page();
        t_window();
        t_partial();
        t_ident();
        t_queue();
        t_clear();
        complete_run();
    end
endmodule // eeprom_host_tb
